/* File: hw/comparator_irq_status.sv */
// Live status, interrupt mask and pending bookkeeping for eight comparator channels and four window pairs.
// Assumes analog results and valid flags arrive as asynchronous levels and interrupt conditions as
// one-cycle pulses from channel logic on ref_clk.
// The clock enable freezes every register, the synchronisers included, so a level that moves while it
// is low is taken up two enabled edges after it returns. All enables, counts and conditions are
// expected to be settled levels or pulses on ref_clk.
//
// Functional notes
// (RULE1) Each window pair shows a live bit: one inside the window, zero outside.
// (RULE2) Channel ready bit is one only when output valid, enabled and startup elapsed.
// (RULE3) Channel comparison bit is one when positive input exceeds negative input.
// (RULE4) Writing ones to the enable port sets those mask bits; zeros change nothing.
// (RULE5) Writing ones to the disable port clears those mask bits; zeros change nothing.
// (RULE6) The mask register reads one for each enabled source, zero for each disabled.
// (RULE7) A window pending bit sets when its pair in window mode raises a condition.
// (RULE8) A startup-done pending bit sets when an enabled channel's startup delay elapses.
// (RULE9) A normal pending bit sets whenever its channel raises an interrupt condition; the code sets it only while the channel is enabled and started.
// (RULE10) A pending bit stays set until software writes one to its clear bit.
// (RULE11) Shared layout: channel n normal at 2n, startup at 2n+1, windows at 24..27.
// (RULE12) Clear-port ones clear pending bit and its request; zeros have no effect.
// (RULE13) After each enable a channel waits the startup count of generic ticks before starting.
// (RULE14) Interrupt line is high while any pending bit meets its set mask bit.
// (RULE15) Write-only ports read zero; writes to read-only registers are ignored.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module comparator_irq_status #(
    // Sizes of the interface: channels, window pairs and the startup count width.
    parameter int NUM_CH = cmp_irq_pkg::NUM_CH,
    parameter int NUM_WIN = cmp_irq_pkg::NUM_WIN,
    parameter int STARTUP_W = cmp_irq_pkg::STARTUP_W
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port
    input wire logic [cmp_irq_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [cmp_irq_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [cmp_irq_pkg::DATA_W-1:0] bus_rdata,
    // Channel control from the comparator interface, on ref_clk
    input wire logic [NUM_CH-1:0] channel_enable,
    input wire logic [STARTUP_W-1:0] startup_delay_count,
    input wire logic gclk_tick,
    // Analog side levels, asynchronous
    input wire logic [NUM_CH-1:0] comparator_output,
    input wire logic [NUM_CH-1:0] comparator_valid,
    input wire logic [NUM_WIN-1:0] window_inside,
    // Interrupt conditions from channel and window logic, one-cycle pulses on ref_clk, and the window mode levels
    input wire logic [NUM_CH-1:0] channel_cond,
    input wire logic [NUM_WIN-1:0] window_mode_en,
    input wire logic [NUM_WIN-1:0] window_cond,
    // Interrupt request and startup state
    output logic irq,
    output logic [NUM_CH-1:0] channel_started
);

    // Synchronised analog levels.
    logic [NUM_CH-1:0] cmp_out_s;
    logic [NUM_CH-1:0] cmp_valid_s;
    logic [NUM_WIN-1:0] win_inside_s;

    // Startup timers.
    logic [NUM_CH-1:0] started;
    logic [NUM_CH-1:0] startup_done;

    // Live flags.
    logic [NUM_CH-1:0] comparison_result_flag;
    logic [NUM_CH-1:0] comparator_ready_flag;
    logic [NUM_WIN-1:0] window_inside_flag;
    logic [31:0] live_status;

    // Interrupt state.
    logic [31:0] mask_ff;
    logic [31:0] nxt_mask;
    logic [31:0] mask_set;
    logic [31:0] mask_clr;
    logic [31:0] pending_ff;
    logic [31:0] nxt_pending;
    logic [31:0] pend_set;
    logic [31:0] pend_clr;
    logic [NUM_CH-1:0] channel_irq;
    logic [NUM_CH-1:0] startup_done_irq;
    logic [NUM_WIN-1:0] window_irq;
    logic [31:0] irq_hits;
    logic nxt_irq;
    logic irq_ff;
    logic [NUM_CH-1:0] started_ff;

    // Register port decode.
    logic wr_enable_port;
    logic wr_disable_port;
    logic wr_clear_port;
    logic [31:0] rd_value;
    logic [31:0] rdata_ff;

    // Offsets are compared in full, so no register has an alias elsewhere in the map; the cost is
    // a wider compare than a decode of the low address bits alone would need.
    function automatic logic addr_hit(input logic [cmp_irq_pkg::ADDR_W-1:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // Each analog level passes two flops before any logic reads it. Bits are not kept coherent
    // with one another, which is harmless because every bit is an independent level.
    sync2 #(
        .W(NUM_CH)
    ) u_sync_out (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in(comparator_output),
        .sync_out(cmp_out_s)
    );

    sync2 #(
        .W(NUM_CH)
    ) u_sync_valid (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in(comparator_valid),
        .sync_out(cmp_valid_s)
    );

    sync2 #(
        .W(NUM_WIN)
    ) u_sync_win (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in(window_inside),
        .sync_out(win_inside_s)
    );

    // One startup timer per channel, restarted on every enable. All channels share one startup
    // count, so channels enabled in the same cycle also start in the same cycle.
    for (genvar n = 0; n < NUM_CH; n++) begin : g_startup
        startup_timer #(
            .W(STARTUP_W)
        ) u_timer (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .enable(channel_enable[n]),
            .gclk_tick(gclk_tick),
            .delay(startup_delay_count),
            .started(started[n]),
            .done_pulse(startup_done[n])
        ); // see (RULE13)
    end

    // Live status. The bits lag the pins by two enabled edges, so a level shorter than that may
    // never be seen by software.
    always_comb begin
        comparison_result_flag = cmp_out_s; // see (RULE3)
        comparator_ready_flag = cmp_valid_s & channel_enable & started; // see (RULE2)
        window_inside_flag = win_inside_s; // see (RULE1)
    end

    always_comb begin
        live_status = cmp_irq_pkg::pack_layout(comparison_result_flag, comparator_ready_flag,
                                               window_inside_flag); // see (RULE11)
    end

    // Interrupt sources. A channel's conditions are ignored until it has started, since its
    // comparison is not yet trusted.
    always_comb begin
        channel_irq = channel_cond & channel_enable & started; // see (RULE9) see (RULE13)
        // A startup pulse that meets a disable in the same cycle is dropped with the channel.
        startup_done_irq = startup_done & channel_enable; // see (RULE8)
        // Window conditions count only while their pair is in window mode.
        window_irq = window_cond & window_mode_en; // see (RULE7)
    end

    always_comb begin
        pend_set = cmp_irq_pkg::pack_layout(channel_irq, startup_done_irq, window_irq); // see (RULE11)
    end

    // Write decode; writes to the read-only offsets fall through and change nothing, and writes
    // to unmapped offsets are ignored the same way.
    always_comb begin
        wr_enable_port = bus_wr && addr_hit(bus_addr, cmp_irq_pkg::OFS_IRQ_ENABLE);
        wr_disable_port = bus_wr && addr_hit(bus_addr, cmp_irq_pkg::OFS_IRQ_DISABLE);
        wr_clear_port = bus_wr && addr_hit(bus_addr, cmp_irq_pkg::OFS_PENDING_CLEAR); // see (RULE15)
    end

    // Enable and disable writes decode into separate set and clear vectors.
    always_comb begin
        mask_set = 32'h0000_0000;
        mask_clr = 32'h0000_0000;
        if (wr_enable_port) begin
            mask_set = bus_wdata & cmp_irq_pkg::IMPL_BITS; // see (RULE4)
        end
        if (wr_disable_port) begin
            mask_clr = bus_wdata & cmp_irq_pkg::IMPL_BITS; // see (RULE5)
        end
    end

    // Mask update; only one write happens per cycle, so set and clear never meet.
    always_comb begin
        nxt_mask = (mask_ff & ~mask_clr) | mask_set;
    end

    // Unimplemented positions are never set, so they read zero.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_ff <= cmp_irq_pkg::RST_MASK;
        end else if (ce) begin
            mask_ff <= nxt_mask;
        end
    end

    // Clear-port ones pick the bits to drop; zeros and unimplemented positions do nothing.
    always_comb begin
        pend_clr = wr_clear_port ? (bus_wdata & cmp_irq_pkg::IMPL_BITS) : 32'h0000_0000; // see (RULE12)
    end

    // Pending update. A new event in the same cycle as its clear wins, so it is never lost.
    always_comb begin
        nxt_pending = (pending_ff & ~pend_clr) | pend_set; // see (RULE10)
    end

    // Reset leaves no source pending, and with the mask clear the request stays low.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pending_ff <= cmp_irq_pkg::RST_PENDING;
        end else if (ce) begin
            pending_ff <= nxt_pending;
        end
    end

    // Sources that are both pending and enabled drive the request.
    always_comb begin
        irq_hits = pending_ff & mask_ff; // see (RULE14)
        nxt_irq = |irq_hits;
    end

    // The request follows the stored state with one cycle of lag, so a clear drops it
    // two edges after the write.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= nxt_irq; // see (RULE14) see (RULE12)
        end
    end

    // The started state leaves through a flop, so the output has no path back into the timers.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            started_ff <= '0;
        end else if (ce) begin
            started_ff <= started;
        end
    end

    // Read mux; write-only ports and unmapped offsets read zero.
    always_comb begin
        case (bus_addr)
            cmp_irq_pkg::OFS_LIVE_STATUS: begin
                // Live status is read straight from the synchronised levels, never latched.
                rd_value = live_status;
            end
            cmp_irq_pkg::OFS_IRQ_MASK: begin
                rd_value = mask_ff; // see (RULE6)
            end
            cmp_irq_pkg::OFS_IRQ_PENDING: begin
                rd_value = pending_ff;
            end
            cmp_irq_pkg::OFS_IRQ_ENABLE,
            cmp_irq_pkg::OFS_IRQ_DISABLE,
            cmp_irq_pkg::OFS_PENDING_CLEAR: begin
                // The write-only ports act on mask and pending state and keep nothing to return.
                rd_value = 32'h0000_0000; // see (RULE15)
            end
            default: begin
                rd_value = 32'h0000_0000; // see (RULE15)
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    // Returning zero between reads keeps a stale word off the port.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff <= cmp_irq_pkg::RST_RDATA;
        end else if (ce) begin
            rdata_ff <= bus_rd ? rd_value : 32'h0000_0000;
        end
    end

    // Every output leaves straight from a register.
    assign bus_rdata = rdata_ff;
    assign irq = irq_ff;
    assign channel_started = started_ff;

endmodule

/* File: hw/startup_timer.sv */
// Startup delay of one comparator channel, counted in generic clock ticks.
// Assumes the tick and the enable come from logic on ref_clk.
`timescale 1ns/10ps
module startup_timer #(
    parameter int W = 10
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Control
    input wire logic enable,
    input wire logic gclk_tick,
    input wire logic [W-1:0] delay,
    // Status
    output logic started,
    output logic done_pulse
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COUNT = 3'b010,
        ST_RUN = 3'b100
    } timer_state_t;

    timer_state_t state_ff;
    logic [W-1:0] cnt_ff;
    logic done_ff;

    // Each new enable restarts the count, so a short disable costs a full startup again.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= '0;
                    if (enable && delay == '0) begin
                        state_ff <= ST_RUN;
                        done_ff <= 1'b1;
                    end else if (enable) begin
                        state_ff <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!enable) begin
                        state_ff <= ST_IDLE;
                    end else if (gclk_tick && cnt_ff == W'(delay - 1'b1)) begin
                        state_ff <= ST_RUN;
                        done_ff <= 1'b1;
                    end else if (gclk_tick) begin
                        cnt_ff <= W'(cnt_ff + 1'b1);
                    end
                end
                ST_RUN: begin
                    if (!enable) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign started = (state_ff == ST_RUN);
    assign done_pulse = done_ff;

endmodule

/* File: hw/sync2.sv */
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 8
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] stable_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            stable_ff <= '0;
        end else if (ce) begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;

endmodule

/* File: shared/cmp_irq_pkg.sv */
// Shared constants and the register bit layout for the comparator status and interrupt block.
// Assumes a 32-bit register port with byte offsets of eight bits.
package cmp_irq_pkg;

    localparam int NUM_CH = 8;
    localparam int NUM_WIN = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STARTUP_W = 10;

    // Register byte offsets.
    localparam logic [7:0] OFS_LIVE_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_DISABLE = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_IRQ_PENDING = 8'h1c;
    localparam logic [7:0] OFS_PENDING_CLEAR = 8'h20;

    // Field positions: channel n uses bits 2n and 2n+1, window pairs start at bit 24.
    localparam int CH_LO_BIT = 0;
    localparam int CH_HI_BIT = 1;
    localparam int WIN_LSB = 24;

    // Reset values and the set of implemented bits.
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_PENDING = 32'h0000_0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    localparam logic [31:0] IMPL_BITS = 32'h0f00_ffff;

    // Places eight low-bit flags, eight high-bit flags and four window flags in the common layout.
    function automatic logic [31:0] pack_layout(input logic [7:0] lo, input logic [7:0] hi, input logic [3:0] win);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int n = 0; n < NUM_CH; n++) begin
            r[2 * n + CH_LO_BIT] = lo[n];
            r[2 * n + CH_HI_BIT] = hi[n];
        end
        for (int w = 0; w < NUM_WIN; w++) begin
            r[WIN_LSB + w] = win[w];
        end
        return r;
    endfunction

endpackage

/* File: sim/cmp_far_side.sv */
// Far side model: comparator result levels, valid levels, window levels and the generic clock tick.
// Assumes the bench sets the wanted levels; the model only times them like an unclocked source.
`timescale 1ns/10ps
module cmp_far_side (
    // Clock
    input wire logic ref_clk,
    // Wanted levels
    input wire logic [7:0] want_out,
    input wire logic [7:0] want_valid,
    input wire logic [3:0] want_win,
    // Block side
    output logic [7:0] comparator_output,
    output logic [7:0] comparator_valid,
    output logic [3:0] window_inside,
    output logic gclk_tick
);
    // Analog levels move between clock edges so the synchronisers see a real asynchronous change.
    assign #3 comparator_output = want_out;
    assign #3 comparator_valid = want_valid;
    assign #3 window_inside = want_win;
    initial gclk_tick = 1'b0;
    always @(posedge ref_clk) begin
        gclk_tick <= ~gclk_tick;
    end
endmodule

/* File: sim/comparator_irq_status_chk.sv */
// Concurrent checks on the register port, request line and startup state of the status block.
// Assumes a bind to comparator_irq_status and a clock enable held high.
`timescale 1ns/10ps
module comparator_irq_status_chk #(
    parameter int NUM_CH = 8,
    parameter int NUM_WIN = 4,
    parameter int STARTUP_W = 10
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    // Channel side
    input wire logic [NUM_CH-1:0] channel_enable,
    input wire logic [STARTUP_W-1:0] startup_delay_count,
    input wire logic [NUM_CH-1:0] comparator_output,
    input wire logic [NUM_WIN-1:0] window_inside,
    input wire logic irq,
    input wire logic [NUM_CH-1:0] channel_started
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_RD_IDLE: assert property (ce && !bus_rd |=> bus_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    AST_WO_ZERO: assert property (bus_rd && (bus_addr == 8'h10 || bus_addr == 8'h14 || bus_addr == 8'h20)
        |=> bus_rdata == 32'h0000_0000) else $error("write-only port read not zero");
    AST_IMPL: assert property (bus_rd |=> (bus_rdata & ~cmp_irq_pkg::IMPL_BITS) == 32'h0000_0000)
        else $error("unimplemented bit read as one");
    AST_EN_SET: assert property (bus_wr && bus_addr == 8'h10 ##1 !bus_wr ##1 bus_rd && bus_addr == 8'h18
        |=> (bus_rdata & $past(bus_wdata, 3) & cmp_irq_pkg::IMPL_BITS) == ($past(bus_wdata, 3) & cmp_irq_pkg::IMPL_BITS))
        else $error("enable write did not set mask");
    AST_DIS_CLR: assert property (bus_wr && bus_addr == 8'h14 ##1 !bus_wr ##1 bus_rd && bus_addr == 8'h18
        |=> (bus_rdata & $past(bus_wdata, 3)) == 32'h0000_0000) else $error("disable write did not clear mask");
    AST_LIVE: assert property ((($stable(comparator_output) && $stable(window_inside))[*4]) ##0
        (bus_rd && bus_addr == 8'h04) |=> bus_rdata[0] == $past(comparator_output[0])
        && bus_rdata[14] == $past(comparator_output[7]) && bus_rdata[27] == $past(window_inside[3]))
        else $error("live status does not follow inputs");
    AST_START_OFF: assert property (!channel_enable[0] [*4] |-> !channel_started[0])
        else $error("channel started while disabled");
    AST_START_WAIT: assert property (!channel_enable[0] [*3] ##1 (channel_enable[0] && startup_delay_count >= 2)
        |-> !channel_started[0] [*3]) else $error("channel started before its delay");
    AST_IRQ_CLR: assert property (bus_wr && bus_addr == 8'h20 && bus_wdata == cmp_irq_pkg::IMPL_BITS
        && channel_enable == 0 ##1 channel_enable == 0 |=> !irq) else $error("request stayed after full clear");
    AST_IRQ_MASK: assert property (bus_wr && bus_addr == 8'h14 && bus_wdata == 32'hffff_ffff |=> ##1 !irq)
        else $error("request high with all sources masked");
endmodule
bind comparator_irq_status comparator_irq_status_chk #(.NUM_CH(NUM_CH), .NUM_WIN(NUM_WIN), .STARTUP_W(STARTUP_W)) chk_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .channel_enable(channel_enable), .startup_delay_count(startup_delay_count),
    .comparator_output(comparator_output), .window_inside(window_inside), .irq(irq), .channel_started(channel_started)
);

/* File: sim/tb_top.sv */
// Register-level bench of the comparator status and interrupt block.
// Assumes the far side model supplies analog levels and the generic tick.
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] channel_enable = 8'h00;
    logic [9:0] startup_delay_count = 10'h003;
    logic [7:0] channel_cond = 8'h00;
    logic [3:0] window_mode_en = 4'h0;
    logic [3:0] window_cond = 4'h0;
    logic [7:0] want_out = 8'h00;
    logic [7:0] want_valid = 8'h00;
    logic [3:0] want_win = 4'h0;
    logic [31:0] bus_rdata, d;
    logic [7:0] comparator_output, comparator_valid, channel_started;
    logic [3:0] window_inside;
    logic gclk_tick, irq;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    cmp_far_side far (.ref_clk(ref_clk), .want_out(want_out), .want_valid(want_valid), .want_win(want_win),
        .comparator_output(comparator_output), .comparator_valid(comparator_valid), .window_inside(window_inside),
        .gclk_tick(gclk_tick));
    comparator_irq_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .channel_enable(channel_enable), .startup_delay_count(startup_delay_count), .gclk_tick(gclk_tick),
        .comparator_output(comparator_output), .comparator_valid(comparator_valid), .window_inside(window_inside),
        .channel_cond(channel_cond), .window_mode_en(window_mode_en), .window_cond(window_cond), .irq(irq),
        .channel_started(channel_started));
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        // The word stands for the cycle after the strobe and is taken at the edge that ends it.
        @(posedge ref_clk);
        v = bus_rdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    // The request is sampled at the edge, before that edge updates it, so drives stay on edges.
    task automatic irq_is(input logic e);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdchk(8'(4 * i + 4), 32'h0000_0000);
        end
        wr(8'h1c, 32'hffff_ffff);
        wr(8'h18, 32'hffff_ffff);
        rdchk(8'h18, 32'h0000_0000);
        rdchk(8'h1c, 32'h0000_0000);
        wr(8'h10, 32'hffff_ffff);
        rdchk(8'h18, cmp_irq_pkg::IMPL_BITS);
        wr(8'h14, 32'h0000_00f0);
        rdchk(8'h18, 32'h0f00_ff0f);
        wr(8'h10, 32'h0000_0000);
        rdchk(8'h18, 32'h0f00_ff0f);
        want_out <= 8'ha5;
        want_valid <= 8'hff;
        want_win <= 4'h9;
        repeat (4) @(posedge ref_clk);
        rdchk(8'h04, 32'h0900_4411);
        channel_enable <= 8'h01;
        repeat (2) @(posedge ref_clk);
        #1 chk({24'h0, channel_started}, 32'h0000_0000);
        d = 32'h0000_0000;
        for (int i = 0; i < 40 && d[1] !== 1'b1; i++) begin
            rd(8'h1c, d);
        end
        chk(d, 32'h0000_0002);
        chk({24'h0, channel_started}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        rdchk(8'h04, 32'h0900_4413);
        window_mode_en <= 4'h4;
        @(posedge ref_clk);
        channel_cond <= 8'h03;
        window_cond <= 4'h6;
        @(posedge ref_clk);
        channel_cond <= 8'h00;
        window_cond <= 4'h0;
        rd(8'h1c, d);
        chk(d & 32'h0000_00ff, 32'h0000_0003);
        chk(d & 32'h0f00_0000, 32'h0400_0000);
        rdchk(8'h1c, 32'h0400_0003);
        wr(8'h20, 32'h0000_0001);
        rdchk(8'h1c, 32'h0400_0002);
        wr(8'h14, 32'hffff_ffff);
        irq_is(1'b0);
        wr(8'h10, 32'h0400_0000);
        irq_is(1'b1);
        channel_enable <= 8'h00;
        repeat (4) @(posedge ref_clk);
        rdchk(8'h04, 32'h0900_4411);
        chk({24'h0, channel_started}, 32'h0000_0000);
        wr(8'h20, cmp_irq_pkg::IMPL_BITS);
        rdchk(8'h1c, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        complete_run();
    end
endmodule
